/* File: rtl/rx_ring_pkg.sv */
// Constants and types for the serial channel zero receive buffering block.
// Assumes a single clock domain and a plain synchronous register port.
package rx_ring_pkg;

    // Register indices on the plain register port
    localparam logic [3:0] ADDR_BUF_FIRST = 4'h0;
    localparam logic [3:0] ADDR_BUF_SECOND = 4'h1;
    localparam logic [3:0] ADDR_BUF_THIRD = 4'h2;
    localparam logic [3:0] ADDR_BUF_FOURTH = 4'h3;
    localparam logic [3:0] ADDR_STATUS_IRQ = 4'h4;
    localparam logic [3:0] ADDR_RING_STATUS = 4'h5;
    localparam logic [3:0] ADDR_RX_CONTROL = 4'h6;
    localparam logic [3:0] ADDR_FOURTH_STATUS = 4'h7;

    // Status/irq register fields
    localparam int FERR_BIT = 0;
    localparam int OERR_BIT = 1;
    localparam int PERR_BIT = 2;
    localparam int MERR_BIT = 3;
    localparam int RX_IE_BIT = 4;
    localparam int RX_IRQ_BIT = 5;
    localparam int TX_IE_BIT = 6;
    localparam int TX_IRQ_BIT = 7;

    // Ring status register groups: second buffer at 1..3, third at 5..7
    localparam int GROUP_SECOND_LSB = 1;
    localparam int GROUP_THIRD_LSB = 5;

    // Receive control fields
    localparam int MP_MODE_BIT = 0;
    localparam int MP_SELECT_BIT = 2;
    localparam int RING_MODE_BIT = 3;
    localparam int PARITY_EN_BIT = 5;
    localparam int PARITY_EVEN_BIT = 6;

    // Reset values
    localparam logic [7:0] STATUS_IRQ_RESET = 8'h00;
    localparam logic [7:0] RING_STATUS_RESET = 8'h11;
    localparam logic [7:0] FOURTH_STATUS_RESET = 8'h00;
    localparam logic [7:0] RX_CONTROL_RESET = 8'h00;

    // One completed frame from the receive shifter
    typedef struct packed {
        logic [7:0] data;
        logic parity_bit;
        logic marker_bit;
        logic stop_bit;
    } rx_frame_s;

    // Error set of one frame
    typedef struct packed {
        logic merr;
        logic perr;
        logic oerr;
    } err_group_s;

endpackage : rx_ring_pkg

/* File: rtl/uart_rx_ring_buffer_status.sv */
// Receive shifter, single or four-stage ring buffer and sticky status flags.
// Assumes serial input synchronous to core_clk_i and a bit-rate sample
// enable pulse from an external divider; registers on a plain port.
//
// Notes on behaviour
// - Ignored frames leave buffers, raise no request
// - Separate 8-bit transmit and receive shifters
// - Completed byte stored, ring order, request raised
// - Shift registers have no software path
// - Status upper nibble irq, lower errors
// - Error bits sticky, set only at reception
// - Unread first buffer sets overrun again
// - Per-buffer errors, one shared framing flag
// - Reset clears first status to zero
// - Stop bit zero sets framing flag
// - Unread first buffer sets overrun, overwrites
// - Parity mismatch sets parity flag
// - Data-select marker one sets mp error
// - Receive request needs receive enable bit
// - Receive flag sticky until software clears
// - Transmit request needs transmit enable bit
// - Transmit flag sticky until software clears
// - Second status holds buffer two, three errors
// - Unread second/third buffer sets overrun
// - Parity mismatch sets second/third parity flag
// - Marker one sets second/third mp flag
// - Unread second/third buffers re-flag overrun
// - Reset loads second status with 11H
// - Control bit 3 selects ring mode
// - Control bit 2 selects data or address
//
// Implementation choices: the address map and strobed register access.
module uart_rx_ring_buffer_status
    import rx_ring_pkg::*;
#(
    parameter int DATA_BITS = 8
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic bit_tick_i,
    input wire logic rx_line_i,
    input wire logic tx_ready_event_i,
    input wire logic [7:0] tx_data_i,
    input wire logic tx_load_i,
    output logic tx_line_o,
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    output logic rx_irq_o,
    output logic tx_irq_o,
    output logic [1:0] ring_ptr_o
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations

    typedef enum logic [1:0] {RX_IDLE, RX_SHIFT, RX_DONE} rx_state_e;

    rx_state_e rx_state;
    logic [DATA_BITS-1:0] rx_shift;
    logic [3:0] rx_count;
    logic [DATA_BITS-1:0] tx_shift;
    logic [3:0] tx_count;
    logic [10:0] rx_bits;
    logic [7:0] buffer [4];
    logic [3:0] unread;
    logic [7:0] status_irq;
    logic [7:0] ring_status;
    logic [7:0] fourth_status;
    logic [7:0] rx_control;
    logic [1:0] ring_ptr;
    rx_frame_s frame;
    logic frame_done;
    logic frame_ignored;
    logic frame_store;
    logic [1:0] target;
    err_group_s frame_err;
    logic [3:0] frame_len;

    // Frame length: start, data, parity if enabled, marker if mp mode, stop
    function automatic logic [3:0] bits_in_frame(input logic [7:0] ctl);
        bits_in_frame = 4'(DATA_BITS) + 4'h2 + {3'h0, ctl[PARITY_EN_BIT]}
                        + {3'h0, ctl[MP_MODE_BIT]};
    endfunction

    // Sticky error group update with set winning over a clear
    function automatic logic [2:0] merge_err(input logic [2:0] old_v,
                                             input logic [2:0] clr_v,
                                             input logic hit,
                                             input err_group_s e);
        merge_err = (old_v & ~clr_v) | (hit ? e : 3'h0);
    endfunction

    assign frame_len = bits_in_frame(rx_control);

    ////////////////////////////////////////////////////////////////////////
    // Receive shifter, invisible to software

    // Receive frame sequencer, sampling once per bit tick
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            rx_state <= RX_IDLE;
            rx_count <= 4'h0;
            rx_bits <= 11'h7FF;
        end else begin
            case (rx_state)
                RX_IDLE: begin
                    if (bit_tick_i && !rx_line_i) begin
                        rx_state <= RX_SHIFT;
                        rx_count <= 4'h1;
                    end
                end
                RX_SHIFT: begin
                    if (bit_tick_i) begin
                        rx_bits <= {rx_line_i, rx_bits[10:1]};
                        rx_count <= rx_count + 4'h1;
                        if (rx_count == frame_len - 4'h1) begin
                            rx_state <= RX_DONE;
                        end
                    end
                end
                RX_DONE: begin
                    rx_state <= RX_IDLE;
                end
                default: begin
                    rx_state <= RX_IDLE;
                end
            endcase
        end
    end

    // Data-only receive shifter, 8 bits wide
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            rx_shift <= '0;
        end else if (rx_state == RX_DONE) begin
            // First data bit is the oldest of frame_len-1 samples ending at bit 10
            rx_shift <= rx_bits[12-int'(frame_len)+:DATA_BITS];
        end
    end

    // Separate transmit shifter, also without a software path
    // Start level goes out at load, so the start bit may run short
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            tx_shift <= '1;
            tx_count <= 4'h0;
            tx_line_o <= 1'b1;
        end else if (tx_load_i && tx_count == 4'h0) begin
            tx_shift <= tx_data_i;
            tx_count <= 4'(DATA_BITS + 1);
            tx_line_o <= 1'b0;
        end else if (bit_tick_i && tx_count != 4'h0) begin
            tx_line_o <= tx_shift[0];
            tx_shift <= {1'b1, tx_shift[DATA_BITS-1:1]};
            tx_count <= tx_count - 4'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Frame decode: one cycle after RX_DONE, fields sit at the top of rx_bits

    // Stop is the newest sample; the marker, when present, sits just below it,
    // and the parity bit below the marker or directly below the stop
    always_comb begin
        frame.stop_bit = rx_bits[10];
        frame.marker_bit = rx_control[MP_MODE_BIT] ? rx_bits[9] : 1'b0;
        frame.parity_bit = rx_control[MP_MODE_BIT] ? rx_bits[8] : rx_bits[9];
        frame.data = rx_shift;
    end

    // Completion, registered on the same edge as the shifter load
    logic done_q;
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            done_q <= 1'b0;
        end else begin
            done_q <= (rx_state == RX_DONE);
        end
    end
    assign frame_done = done_q;

    // Address select drops frames without the marker
    assign frame_ignored = rx_control[MP_MODE_BIT] && rx_control[MP_SELECT_BIT]
                           && !frame.marker_bit;
    assign frame_store = frame_done && !frame_ignored;
    assign target = rx_control[RING_MODE_BIT] ? ring_ptr : 2'h0;

    // Per-frame error set: overrun, parity, mp
    always_comb begin
        frame_err.oerr = unread[target];
        // Xor of data and parity is 0 when good in even mode, 1 in odd mode,
        // so an error shows when the xor equals the even-mode bit
        frame_err.perr = rx_control[PARITY_EN_BIT] &&
                         ((^frame.data ^ frame.parity_bit) == rx_control[PARITY_EVEN_BIT]);
        frame_err.merr = rx_control[MP_MODE_BIT] && !rx_control[MP_SELECT_BIT]
                         && frame.marker_bit;
    end

    ////////////////////////////////////////////////////////////////////////
    // Buffers and ring pointer

    // Store received byte, overwriting unread data
    always_ff @(posedge core_clk_i) begin
        if (frame_store) begin
            buffer[target] <= frame.data;
        end
    end

    // Ring pointer advances on stores only, wraps after the fourth
    // Leaving ring mode parks it at the first buffer
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            ring_ptr <= 2'h0;
        end else if (!rx_control[RING_MODE_BIT]) begin
            ring_ptr <= 2'h0;
        end else if (frame_store) begin
            ring_ptr <= ring_ptr + 2'h1;
        end
    end
    assign ring_ptr_o = ring_ptr;

    // Unread markers: set on store, cleared by a read; store wins
    // A read in the store cycle loses, so the next fill still flags overrun
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            unread <= 4'h0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (frame_store && target == 2'(i)) begin
                    unread[i] <= 1'b1;
                end else if (rd_i && addr_i == 4'(i)) begin
                    unread[i] <= 1'b0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status registers

    logic wr_status;
    logic wr_ring;
    logic wr_fourth;
    assign wr_status = wr_i && addr_i == ADDR_STATUS_IRQ;
    assign wr_ring = wr_i && addr_i == ADDR_RING_STATUS;
    assign wr_fourth = wr_i && addr_i == ADDR_FOURTH_STATUS;

    // First status: errors lower nibble, irq controls upper nibble
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            status_irq <= STATUS_IRQ_RESET;
        end else begin
            // Software may write enables and clear flags by writing zero
            // Set terms are or-ed in after the clear, so a same-cycle event wins
            status_irq[RX_IE_BIT] <= wr_status ? wdata_i[RX_IE_BIT]
                                               : status_irq[RX_IE_BIT];
            status_irq[TX_IE_BIT] <= wr_status ? wdata_i[TX_IE_BIT]
                                               : status_irq[TX_IE_BIT];
            status_irq[FERR_BIT] <= (status_irq[FERR_BIT] &
                                     ~(wr_status & ~wdata_i[FERR_BIT]))
                                    | (frame_store & ~frame.stop_bit);
            status_irq[MERR_BIT:OERR_BIT] <= merge_err(status_irq[MERR_BIT:OERR_BIT],
                {3{wr_status}} & ~wdata_i[MERR_BIT:OERR_BIT],
                frame_store && target == 2'h0, frame_err);
            status_irq[RX_IRQ_BIT] <= (status_irq[RX_IRQ_BIT] &
                                       ~(wr_status & ~wdata_i[RX_IRQ_BIT]))
                                      | frame_store;
            status_irq[TX_IRQ_BIT] <= (status_irq[TX_IRQ_BIT] &
                                       ~(wr_status & ~wdata_i[TX_IRQ_BIT]))
                                      | tx_ready_event_i;
        end
    end

    // Second status: buffer two at bits 1..3, buffer three at 5..7
    // Bits 0 and 4 are never assigned and keep their reset ones
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            ring_status <= RING_STATUS_RESET;
        end else begin
            ring_status[GROUP_SECOND_LSB+:3] <= merge_err(ring_status[GROUP_SECOND_LSB+:3],
                {3{wr_ring}} & ~wdata_i[GROUP_SECOND_LSB+:3],
                frame_store && target == 2'h1, frame_err);
            ring_status[GROUP_THIRD_LSB+:3] <= merge_err(ring_status[GROUP_THIRD_LSB+:3],
                {3{wr_ring}} & ~wdata_i[GROUP_THIRD_LSB+:3],
                frame_store && target == 2'h2, frame_err);
        end
    end

    // Fourth buffer errors at bits 1..3, pointer readable at 4..5
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            fourth_status <= FOURTH_STATUS_RESET;
        end else begin
            fourth_status[GROUP_SECOND_LSB+:3] <= merge_err(
                fourth_status[GROUP_SECOND_LSB+:3],
                {3{wr_fourth}} & ~wdata_i[GROUP_SECOND_LSB+:3],
                frame_store && target == 2'h3, frame_err);
        end
    end

    // Receive control, written by software
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            rx_control <= RX_CONTROL_RESET;
        end else if (wr_i && addr_i == ADDR_RX_CONTROL) begin
            rx_control <= wdata_i;
        end
    end

    // Interrupt requests gated by their enables
    assign rx_irq_o = status_irq[RX_IRQ_BIT] & status_irq[RX_IE_BIT];
    assign tx_irq_o = status_irq[TX_IRQ_BIT] & status_irq[TX_IE_BIT];

    ////////////////////////////////////////////////////////////////////////
    // Read port: shift registers are not mapped

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            rdata_o <= 8'h00;
        end else if (rd_i) begin
            case (addr_i)
                ADDR_BUF_FIRST: rdata_o <= buffer[0];
                ADDR_BUF_SECOND: rdata_o <= buffer[1];
                ADDR_BUF_THIRD: rdata_o <= buffer[2];
                ADDR_BUF_FOURTH: rdata_o <= buffer[3];
                ADDR_STATUS_IRQ: rdata_o <= status_irq;
                ADDR_RING_STATUS: rdata_o <= ring_status;
                ADDR_RX_CONTROL: rdata_o <= rx_control;
                ADDR_FOURTH_STATUS: rdata_o <= {2'h0, ring_ptr, fourth_status[3:1], 1'b0};
                default: rdata_o <= 8'h00;
            endcase
        end else begin
            rdata_o <= 8'h00;
        end
    end

endmodule // uart_rx_ring_buffer_status

/* File: dv/rx_ring_asserts.sv */
// Checker for the register port and request lines of the receive block.
// Assumes one clock domain; bound to the top module below.
module rx_ring_asserts
    import rx_ring_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic bit_tick_i,
    input wire logic tx_ready_event_i,
    input wire logic [3:0] addr_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic rx_irq_o,
    input wire logic tx_irq_o,
    input wire logic tx_line_o,
    input wire logic [1:0] ring_ptr_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    logic stat_wr;
    logic stat_rd;
    // Status register accesses
    assign stat_wr = wr_i && addr_i == ADDR_STATUS_IRQ;
    assign stat_rd = rd_i && addr_i == ADDR_STATUS_IRQ;
    property p_reset;
        disable iff (1'b0) rst_i |=> rdata_o == 8'h00 && !rx_irq_o && !tx_irq_o
            && ring_ptr_o == 2'h0 && tx_line_o;
    endproperty
    a_reset: assert property (p_reset) else $error("outputs not at reset values");
    property p_rdata_idle;
        !rd_i |=> rdata_o == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data without read");
    property p_unmapped;
        rd_i && addr_i[3] |=> rdata_o == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_ring_fixed;
        rd_i && addr_i == ADDR_RING_STATUS |=> rdata_o[0] && rdata_o[4];
    endproperty
    a_ring_fixed: assert property (p_ring_fixed) else $error("fixed ring bits lost");
    property p_rx_view;
        stat_rd |=> (rdata_o[5] && rdata_o[4]) == $past(rx_irq_o);
    endproperty
    a_rx_view: assert property (p_rx_view) else $error("rx request mismatch");
    property p_tx_view;
        stat_rd |=> (rdata_o[7] && rdata_o[6]) == $past(tx_irq_o);
    endproperty
    a_tx_view: assert property (p_tx_view) else $error("tx request mismatch");
    property p_rx_hold;
        rx_irq_o && !stat_wr |=> rx_irq_o;
    endproperty
    a_rx_hold: assert property (p_rx_hold) else $error("rx request dropped");
    property p_tx_hold;
        tx_irq_o && !stat_wr |=> tx_irq_o;
    endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("tx request dropped");
    property p_tx_cause;
        $rose(tx_irq_o) |-> $past(tx_ready_event_i) || $past(stat_wr);
    endproperty
    a_tx_cause: assert property (p_tx_cause) else $error("tx request uncaused");
    property p_rx_cause;
        $rose(rx_irq_o) |-> $past(stat_wr) || $past(bit_tick_i, 3);
    endproperty
    a_rx_cause: assert property (p_rx_cause) else $error("rx request uncaused");
    property p_ptr_step;
        $changed(ring_ptr_o) && !$past(wr_i, 2) |->
            ring_ptr_o == $past(ring_ptr_o) + 2'h1 && $past(bit_tick_i, 3);
    endproperty
    a_ptr_step: assert property (p_ptr_step) else $error("ring pointer jump");
endmodule // rx_ring_asserts

bind uart_rx_ring_buffer_status rx_ring_asserts u_rx_ring_asserts (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .bit_tick_i(bit_tick_i),
    .tx_ready_event_i(tx_ready_event_i), .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .rx_irq_o(rx_irq_o), .tx_irq_o(tx_irq_o), .tx_line_o(tx_line_o),
    .ring_ptr_o(ring_ptr_o));

/* File: dv/serial_tx_model.sv */
// Remote serial transmitter driving the receive line, one bit per tick.
// Assumes the tick is driven by non-blocking assignment on the clock edge.
module serial_tx_model (
    input wire logic clk_i,
    input wire logic tick_i,
    output logic line_o
);
    timeunit 1ns;
    timeprecision 1ns;
    int missed = 0;
    initial line_o = 1'b1;
    // Send n bits LSB first, then return the line to idle high
    task automatic send(input logic [11:0] bits, input int n);
        int i;
        int k;
        for (i = 0; i <= n; i++) begin
            k = 0;
            @(posedge clk_i);
            while (!tick_i && k < 16) begin
                @(posedge clk_i);
                k++;
            end
            if (k == 16) missed++;
            line_o <= (i < n) ? bits[i] : 1'b1;
        end
    endtask
endmodule // serial_tx_model

/* File: dv/tb.sv */
// Self-checking bench for the receive buffering block.
// Assumes the serial transmitter model drives the receive line.
module tb
    import rx_ring_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk_i = 0, rst_i = 1, bit_tick_i = 0, tx_ready_event_i = 0;
    logic tx_load_i = 0, wr_i = 0, rd_i = 0, rx_line_i, tx_line_o, rx_irq_o, tx_irq_o;
    logic [7:0] tx_data_i = 0, wdata_i = 0, rdata_o;
    logic [3:0] addr_i = 0;
    logic [1:0] ring_ptr_o, tick_cnt = 0;
    int err_count = 0, samples_checked = 0, seed, ptr = 0, c, i, k;
    logic [7:0] eb [4], ctab [6], e_stat = 8'h00, e_ring = 8'h11, e_ctrl = 8'h00;
    logic [7:0] e_four = 8'h00;
    bit unread [4];
    logic [31:0] r;
    logic [9:0] txb = 0;
    uart_rx_ring_buffer_status #(.DATA_BITS(8)) u_uart_rx_ring_buffer_status (
        .core_clk_i(core_clk_i), .rst_i(rst_i), .bit_tick_i(bit_tick_i),
        .rx_line_i(rx_line_i), .tx_ready_event_i(tx_ready_event_i), .tx_data_i(tx_data_i),
        .tx_load_i(tx_load_i), .tx_line_o(tx_line_o), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .rx_irq_o(rx_irq_o),
        .tx_irq_o(tx_irq_o), .ring_ptr_o(ring_ptr_o));
    serial_tx_model u_serial_tx_model (.clk_i(core_clk_i), .tick_i(bit_tick_i),
        .line_o(rx_line_i));
    ////////////////////////////////////////////////////////////////////////////
    // Clock and bit-rate enable, one cycle in four
    always #25 core_clk_i = ~core_clk_i;
    always @(posedge core_clk_i) begin
        tick_cnt <= tick_cnt + 2'h1;
        bit_tick_i <= (tick_cnt == 2'h3);
    end
    task automatic print_verdict();
        if (err_count == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: read %h, model %h", $time, got, exp);
        end
    endtask
    function automatic logic [7:0] exp_of(input logic [3:0] a);
        case (a)
            ADDR_STATUS_IRQ: return e_stat;
            ADDR_RING_STATUS: return e_ring;
            ADDR_RX_CONTROL: return e_ctrl;
            ADDR_FOURTH_STATUS: return e_four | 8'(ptr << 4);
            default: return (a < 4) ? eb[a[1:0]] : 8'h00;
        endcase
    endfunction
    ////////////////////////////////////////////////////////////////////////////
    // Register port tasks with the model kept beside them
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge core_clk_i);
        wr_i <= 1'b0;
        case (a)
            ADDR_STATUS_IRQ: e_stat = (e_stat & d & 8'hAF) | (d & 8'h50);
            ADDR_RING_STATUS: e_ring = (e_ring & d) | 8'h11;
            ADDR_RX_CONTROL: e_ctrl = d;
            ADDR_FOURTH_STATUS: e_four = e_four & d & 8'h0E;
            default: ;
        endcase
    endtask
    task automatic rd_chk(input logic [3:0] a);
        logic [7:0] e;
        e = exp_of(a);
        @(posedge core_clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge core_clk_i);
        rd_i <= 1'b0;
        if (a < 4) unread[a[1:0]] = 0;
        #1;
        if (!$isunknown(e)) check(rdata_o, e);
    endtask
    task automatic chk_regs();
        rd_chk(ADDR_STATUS_IRQ);
        rd_chk(ADDR_RING_STATUS);
        rd_chk(ADDR_FOURTH_STATUS);
        check({7'h0, rx_irq_o}, {7'h0, e_stat[5] & e_stat[4]});
        check({7'h0, tx_irq_o}, {7'h0, e_stat[7] & e_stat[6]});
        check({6'h0, ring_ptr_o}, 8'(ptr));
    endtask
    // One frame on the line, then the model's view of its effect
    task automatic rx_frame(input logic [7:0] d, input logic p, input logic m, input logic s);
        logic [11:0] b;
        logic [2:0] g;
        int n;
        int t;
        b = {3'b000, d, 1'b0};
        n = 9;
        // Optional fields: each is written, then kept only if enabled
        b[n] = p;
        n += int'(e_ctrl[5]);
        b[n] = m;
        n += int'(e_ctrl[0]);
        b[n] = s;
        u_serial_tx_model.send(b, n + 1);
        repeat (4) @(posedge core_clk_i);
        if (e_ctrl[0] && e_ctrl[2] && !m) return;
        t = e_ctrl[3] ? ptr : 0;
        g = {e_ctrl[0] && !e_ctrl[2] && m, e_ctrl[5] && ((^{d, p}) == e_ctrl[6]), unread[t]};
        case (t)
            0: e_stat[3:1] |= g;
            1: e_ring[3:1] |= g;
            2: e_ring[7:5] |= g;
            default: e_four[3:1] |= g;
        endcase
        e_stat[0] |= !s;
        e_stat[5] = 1'b1;
        eb[t] = d;
        unread[t] = 1;
        if (e_ctrl[3]) ptr = (ptr + 1) % 4;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Hang guard
    initial begin
        repeat (100000) @(posedge core_clk_i);
        err_count++;
        print_verdict();
    end
    // Main sequence
    initial begin
        seed = 72222;
        ctab = '{8'h20, 8'h60, 8'h01, 8'h05, 8'h08, 8'h2D};
        repeat (16) @(posedge core_clk_i);
        rst_i <= 1'b0;
        chk_regs();
        rd_chk(ADDR_RX_CONTROL);
        rd_chk(4'hC);
        r = $random(seed);
        @(posedge core_clk_i);
        tx_data_i <= r[7:0];
        tx_load_i <= 1'b1;
        @(posedge core_clk_i);
        tx_load_i <= 1'b0;
        k = 0;
        for (i = 0; i < 80 && k < 10; i++) begin
            @(posedge core_clk_i);
            if (bit_tick_i && (k > 0 || tx_line_o === 1'b0)) begin
                txb[k] = tx_line_o;
                k++;
            end
        end
        check(txb[8:1], r[7:0]);
        check({7'h0, txb[9]}, 8'h01);
        for (c = 0; c < 6; c++) begin
            wr(ADDR_RX_CONTROL, ctab[c]);
            for (i = 0; i < 6; i++) begin
                r = $random(seed);
                rx_frame(r[7:0], r[8], r[9], r[10] | r[11]);
                chk_regs();
                if (r[12]) rd_chk(e_ctrl[3] ? {2'b00, r[14:13]} : ADDR_BUF_FIRST);
                if (r[15]) begin
                    @(posedge core_clk_i);
                    tx_ready_event_i <= 1'b1;
                    @(posedge core_clk_i);
                    tx_ready_event_i <= 1'b0;
                    e_stat[7] = 1'b1;
                end
                if (r[16]) wr(ADDR_STATUS_IRQ, r[24:17]);
                if (r[25]) wr(r[26] ? ADDR_RING_STATUS : ADDR_FOURTH_STATUS, r[24:17]);
                if (r[27]) rd_chk({1'b1, r[30:28]});
            end
        end
        chk_regs();
        check(8'(u_serial_tx_model.missed), 8'h00);
        print_verdict();
    end
endmodule // tb
